// ===== logic/xmb_defs.vh
// Constants for the external memory bus interface
`ifndef XMB_DEFS_VH
`define XMB_DEFS_VH
// ********************************************************
// Timing
// ********************************************************
`define XMB_CLKS_PER_MC      3'h4
`define XMB_RST_MC_MIN       3'h2
`define XMB_RST_CLKS         4'h8
`define XMB_STRETCH_MIN      4'h2
`define XMB_STRETCH_MAX      4'h9
`define XMB_STRETCH_RESET    4'h2
`endif

// ===== logic/xmb_bus.v
// External program and data memory bus engine
// Contract
// R1 - Every machine cycle lasts four clocks; all bus timing follows it.
// R2 - Code select low forces every code fetch onto the external bus.
// R3 - System holds code select high when running from internal storage.
// R4 - Internal fetches with code select high show nothing on the bus.
// R5 - Program read strobe asserted for external fetches and code table reads.
// R6 - Internal fetches never pulse the program read strobe.
// R7 - Address latch strobe lets an external latch grab the low address.
// R8 - Low address and data share the low port in time.
// R9 - Upper eight address bits driven on the upper port during accesses.
// R10 - Reset needs reset input high for two machine cycles.
// R11 - Software picks the external data access duration.
// R12 - Low port pull-ups enabled only under software control.
// R13 - Data access lasts two to nine machine cycles.
// R14 - Separate write and read strobes for external data accesses.
// R15 - Program read strobe active low; latch strobe falls with address stable.
`include "xmb_defs.vh"
module xmb_bus (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        reset_pin,
  output wire        core_reset,
  input  wire        external_code_select_n,
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [1:0]  req_kind,
  input  wire [15:0] req_addr,
  input  wire [7:0]  req_wdata,
  input  wire [3:0]  stretch_cfg,
  input  wire        pullup_en,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_data,
  output reg         rsp_internal,
  output reg         address_latch_strobe,
  output reg         program_read_strobe_n,
  output reg         data_read_strobe_n,
  output reg         data_write_strobe_n,
  input  wire [7:0]  low_addr_data_in,
  output reg  [7:0]  low_addr_data_out,
  output reg  [7:0]  low_addr_data_oe,
  output wire        low_addr_pullup_en,
  output reg  [7:0]  upper_addr_port
);
// ********************************************************
// Request kinds and states
// ********************************************************
localparam [1:0] K_FETCH = 2'h0;
localparam [1:0] K_CTAB  = 2'h1;
localparam [1:0] K_DRD   = 2'h2;
localparam [1:0] K_DWR   = 2'h3;
localparam [3:0] S_IDLE  = 4'h1;
localparam [3:0] S_ADDR  = 4'h2;
localparam [3:0] S_DATA  = 4'h4;
localparam [3:0] S_INT   = 4'h8;

// ********************************************************
// Registers and internal wires
// ********************************************************
reg [3:0]  state_reg;
reg [3:0]  state_next;
reg [1:0]  phase_reg;
reg [3:0]  mc_left_reg;
reg [1:0]  kind_reg;
reg [7:0]  wdata_reg;
reg [3:0]  rst_cnt_reg;
reg        core_reset_reg;
reg [3:0]  stretch_reg;
wire       mc_end;
wire       is_data;
wire       data_done;
wire       take;
wire       take_ext;
wire       addr_end;
wire       data_mc_end;
wire       data_end;
wire       int_end;

// ********************************************************
// Reset pin qualification
// ********************************************************
always @(posedge mclk) begin
  if (!resetn) begin
    rst_cnt_reg    <= 4'h0;
    core_reset_reg <= 1'h1;
  end else if (reset_pin) begin
    if (rst_cnt_reg != `XMB_RST_CLKS) begin
      rst_cnt_reg <= rst_cnt_reg + 4'h1;
    end
    if (rst_cnt_reg == `XMB_RST_CLKS - 4'h1) begin
      core_reset_reg <= 1'h1; // R10
    end
  end else begin
    rst_cnt_reg    <= 4'h0;
    core_reset_reg <= 1'h0;
  end
end
assign core_reset = core_reset_reg;

// ********************************************************
// Access duration, clamped to legal range
// ********************************************************
always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    stretch_reg <= `XMB_STRETCH_RESET;
  end else if (stretch_cfg < `XMB_STRETCH_MIN) begin
    stretch_reg <= `XMB_STRETCH_MIN; // R13
  end else if (stretch_cfg > `XMB_STRETCH_MAX) begin
    stretch_reg <= `XMB_STRETCH_MAX; // R13
  end else begin
    stretch_reg <= stretch_cfg; // R11
  end
end

assign low_addr_pullup_en = pullup_en; // R12

// ********************************************************
// Machine cycle phase
// ********************************************************
always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    phase_reg <= 2'h0;
  end else begin
    phase_reg <= phase_reg + 2'h1; // R1
  end
end
assign mc_end    = (phase_reg == 2'h3);
assign is_data   = kind_reg[1];
assign req_ready = (state_reg == S_IDLE) && mc_end && !core_reset_reg;
assign data_done = (mc_left_reg == 4'h1);

// ********************************************************
// Bus sequencer
// ********************************************************
always @* begin
  state_next = state_reg;
  case (state_reg)
    S_IDLE: begin
      if (req_valid && req_ready) begin
        if (req_kind == K_FETCH && external_code_select_n) begin
          state_next = S_INT; // R4
        end else begin
          state_next = S_ADDR; // R2
        end
      end
    end
    S_ADDR: begin
      if (mc_end) begin
        state_next = S_DATA;
      end
    end
    S_DATA: begin
      if (mc_end && (!is_data || data_done)) begin
        state_next = S_IDLE;
      end
    end
    S_INT: begin
      if (mc_end) begin
        state_next = S_IDLE;
      end
    end
    default: state_next = S_IDLE;
  endcase
end

// ********************************************************
// Sequencer events
// ********************************************************
assign take        = (state_reg == S_IDLE) && req_valid && req_ready;
assign take_ext    = take && (state_next == S_ADDR);
assign addr_end    = (state_reg == S_ADDR) && mc_end;
assign data_mc_end = (state_reg == S_DATA) && mc_end;
assign data_end    = data_mc_end && (!is_data || data_done);
assign int_end     = (state_reg == S_INT) && mc_end;

// ********************************************************
// State and request capture
// ********************************************************
always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    state_reg <= S_IDLE;
  end else begin
    state_reg <= state_next;
  end
end

always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    kind_reg  <= K_FETCH;
    wdata_reg <= 8'h00;
  end else if (take) begin
    kind_reg  <= req_kind;
    wdata_reg <= req_wdata;
  end
end

// ********************************************************
// Data access countdown
// ********************************************************
always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    mc_left_reg <= 4'h0;
  end else if (take) begin
    mc_left_reg <= stretch_reg - 4'h1; // R13
  end else if (data_mc_end && is_data && !data_done) begin
    mc_left_reg <= mc_left_reg - 4'h1; // R13
  end
end

// ********************************************************
// Address phase
// ********************************************************
always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    upper_addr_port <= 8'h00;
  end else if (take_ext) begin
    upper_addr_port <= req_addr[15:8]; // R9
  end
end

always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    address_latch_strobe <= 1'h0;
  end else if (take_ext) begin
    address_latch_strobe <= 1'h1; // R7
  end else if (state_reg == S_ADDR && phase_reg == 2'h1) begin
    address_latch_strobe <= 1'h0; // R15
  end
end

// ********************************************************
// Read and write strobes
// ********************************************************
always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    program_read_strobe_n <= 1'h1;
  end else if (addr_end && !is_data) begin
    program_read_strobe_n <= 1'h0; // R5 R15
  end else if (data_end) begin
    program_read_strobe_n <= 1'h1;
  end
end

always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    data_read_strobe_n <= 1'h1;
  end else if (addr_end && kind_reg == K_DRD) begin
    data_read_strobe_n <= 1'h0; // R14
  end else if (data_end) begin
    data_read_strobe_n <= 1'h1;
  end
end

always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    data_write_strobe_n <= 1'h1;
  end else if (addr_end && kind_reg == K_DWR) begin
    data_write_strobe_n <= 1'h0; // R14
  end else if (data_end) begin
    data_write_strobe_n <= 1'h1;
  end
end

// ********************************************************
// Low address and data port driver
// ********************************************************
always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    low_addr_data_out <= 8'h00;
  end else if (take_ext) begin
    low_addr_data_out <= req_addr[7:0]; // R8
  end else if (addr_end && kind_reg == K_DWR) begin
    low_addr_data_out <= wdata_reg; // R8
  end
end

always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    low_addr_data_oe <= 8'h00;
  end else if (take_ext) begin
    low_addr_data_oe <= 8'hFF;
  end else if (addr_end && kind_reg != K_DWR) begin
    low_addr_data_oe <= 8'h00; // R8
  end else if (data_end) begin
    low_addr_data_oe <= 8'h00;
  end
end

// ********************************************************
// Response
// ********************************************************
always @(posedge mclk) begin
  if (!resetn || core_reset_reg) begin
    rsp_valid    <= 1'h0;
    rsp_internal <= 1'h0;
    rsp_data     <= 8'h00;
  end else begin
    rsp_valid <= data_end || int_end;
    if (data_end) begin
      rsp_internal <= 1'h0;
      rsp_data     <= (kind_reg == K_DWR) ? wdata_reg : low_addr_data_in;
    end else if (int_end) begin
      rsp_internal <= 1'h1; // R6
      rsp_data     <= 8'h00;
    end
  end
end

endmodule

// ===== testbench/xmb_bus_props.sv
// Assertion checker for the external memory bus engine
module xmb_bus_props (
  input logic       mclk,
  input logic       resetn,
  input logic       reset_pin,
  input logic       core_reset,
  input logic       external_code_select_n,
  input logic       req_valid,
  input logic       req_ready,
  input logic [1:0] req_kind,
  input logic       rsp_valid,
  input logic       address_latch_strobe,
  input logic       program_read_strobe_n,
  input logic       data_read_strobe_n,
  input logic       data_write_strobe_n,
  input logic [7:0] low_addr_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bus properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire tk = req_valid && req_ready && !core_reset;
  wire tk_ext = tk && (req_kind == 2'h1 || req_kind == 2'h0 && !external_code_select_n);
  wire quiet = program_read_strobe_n && !address_latch_strobe && low_addr_data_oe == 8'h00;
  sequence s_alat; (address_latch_strobe && low_addr_data_oe == 8'hFF)[*2]; endsequence
  sequence s_pread; (!program_read_strobe_n && low_addr_data_oe == 8'h00)[*4]; endsequence
  property p_ready; req_ready |=> !req_ready[*3]; endproperty
  a_ready: assert property (p_ready) else $error("ready too often");
  property p_int; tk && req_kind == 2'h0 && external_code_select_n |=> quiet[*4] ##[0:1] rsp_valid; endproperty
  a_int: assert property (p_int) else $error("internal fetch on bus");
  property p_ext; tk_ext |=> s_alat ##1 (!address_latch_strobe && low_addr_data_oe == 8'hFF) ##2 s_pread ##[0:1] rsp_valid; endproperty
  a_ext: assert property (p_ext) else $error("bad external fetch");
  property p_wr; tk && req_kind == 2'h3 |-> ##[4:5] (!data_write_strobe_n && low_addr_data_oe == 8'hFF)[*4]; endproperty
  a_wr: assert property (p_wr) else $error("bad data write");
  property p_rd; tk && req_kind == 2'h2 |-> ##[4:5] (!data_read_strobe_n && low_addr_data_oe == 8'h00)[*4]; endproperty
  a_rd: assert property (p_rd) else $error("bad data read");
  property p_rst; reset_pin[*8] |-> ##[0:1] core_reset; endproperty
  a_rst: assert property (p_rst) else $error("long reset ignored");
  property p_short; !core_reset && !reset_pin ##1 reset_pin[*4] ##1 !reset_pin |-> !core_reset; endproperty
  a_short: assert property (p_short) else $error("short reset taken");
  property p_fall; $fell(program_read_strobe_n) |-> $past(address_latch_strobe, 4); endproperty
  a_fall: assert property (p_fall) else $error("read without latch");
endmodule
bind xmb_bus xmb_bus_props xmb_props_u (.mclk, .resetn, .reset_pin, .core_reset, .external_code_select_n, .req_valid,
  .req_ready, .req_kind, .rsp_valid, .address_latch_strobe, .program_read_strobe_n, .data_read_strobe_n,
  .data_write_strobe_n, .low_addr_data_oe);

// ===== testbench/xmb_mem_model.sv
// External ROM, data RAM and address latch
module xmb_mem_model (
  input  logic       mclk,
  input  logic       address_latch_strobe,
  input  logic       program_read_strobe_n,
  input  logic       data_read_strobe_n,
  input  logic       data_write_strobe_n,
  input  logic       low_addr_pullup_en,
  input  logic [7:0] low_addr_data_out,
  input  logic [7:0] low_addr_data_oe,
  input  logic [7:0] upper_addr_port,
  output logic [7:0] low_addr_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Memories
  // ****
  logic [7:0] lat_reg, last_reg, drv, ram [0:255];
  always @(posedge mclk) begin
    if (address_latch_strobe) lat_reg <= low_addr_data_in;
    if (!data_write_strobe_n) ram[lat_reg] <= low_addr_data_in;
    last_reg <= low_addr_data_in;
  end
  always_comb begin
    drv = !program_read_strobe_n ? lat_reg ^ upper_addr_port ^ 8'h5A : ram[lat_reg];
    if (!program_read_strobe_n || !data_read_strobe_n) low_addr_data_in = drv;
    else low_addr_data_in = (low_addr_data_oe & low_addr_data_out) | (~low_addr_data_oe & (low_addr_pullup_en ? 8'hFF : ~last_reg));
  end
endmodule

// ===== testbench/xmb_bus_tb.sv
// Self-checking bench for the external memory bus engine
module xmb_bus_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'h0, resetn = 1'h0, reset_pin = 1'h0, external_code_select_n = 1'h1, req_valid = 1'h0;
  logic        pullup_en = 1'h0, core_reset, req_ready, rsp_valid, rsp_internal, address_latch_strobe;
  logic        program_read_strobe_n, data_read_strobe_n, data_write_strobe_n, low_addr_pullup_en;
  logic [1:0]  req_kind = 2'h0;
  logic [3:0]  stretch_cfg = 4'h0;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0]  req_wdata = 8'h00, rsp_data, low_addr_data_in, low_addr_data_out, low_addr_data_oe, upper_addr_port, d;
  int          miscompares = 0, samples_checked = 0, n;
  always #2 mclk = ~mclk;
  xmb_bus dut_u (.mclk, .resetn, .reset_pin, .core_reset, .external_code_select_n, .req_valid, .req_ready, .req_kind,
    .req_addr, .req_wdata, .stretch_cfg, .pullup_en, .rsp_valid, .rsp_data, .rsp_internal, .address_latch_strobe,
    .program_read_strobe_n, .data_read_strobe_n, .data_write_strobe_n, .low_addr_data_in, .low_addr_data_out,
    .low_addr_data_oe, .low_addr_pullup_en, .upper_addr_port);
  xmb_mem_model mem_u (.mclk, .address_latch_strobe, .program_read_strobe_n, .data_read_strobe_n,
    .data_write_strobe_n, .low_addr_pullup_en, .low_addr_data_out, .low_addr_data_oe, .upper_addr_port,
    .low_addr_data_in);
  // ****
  // Scenarios
  // ****
  task chk(input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task summarize;
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wt(ref logic s, input logic v);
    int i;
    for (i = 0; s !== v && i < 60; i++) @(negedge mclk);
    chk(16'(i < 60), 16'h0001);
    if (i == 60) summarize;
  endtask
  task automatic req(input logic [1:0] k, input logic [15:0] a, input logic [7:0] w);
    @(negedge mclk);
    {req_valid, req_kind, req_addr, req_wdata} = {1'h1, k, a, w};
    wt(req_ready, 1'h1);
    @(negedge mclk);
    req_valid = 1'h0;
    wt(rsp_valid, 1'h0);
    for (n = 0; rsp_valid !== 1'h1 && n < 60; n++) @(negedge mclk);
    chk(16'(n < 60), 16'h0001);
    if (n == 60) summarize;
    d = rsp_data;
  endtask
  task t_fetch;
    external_code_select_n = 1'h1;
    pullup_en = 1'h0;
    @(negedge mclk);
    chk(low_addr_pullup_en, 1'h0);
    pullup_en = 1'h1;
    @(negedge mclk);
    chk(low_addr_pullup_en, 1'h1);
    req(2'h0, 16'h1234, 8'h00);
    chk({7'h00, rsp_internal, n[7:0]}, 16'h0104);
    chk({8'h00, d}, 16'h0000);
    req(2'h1, 16'h3C5A, 8'h00);
    chk({d, n[7:0]}, 16'h3C08);
    external_code_select_n = 1'h0;
    req(2'h0, 16'hA5F0, 8'h00);
    chk({d, upper_addr_port}, 16'h0FA5);
  endtask
  task t_data;
    logic [3:0] cfg [4] = '{4'h0, 4'h2, 4'h9, 4'hF};
    int e;
    foreach (cfg[i]) begin
      stretch_cfg = cfg[i];
      e = cfg[i] < 2 ? 2 : cfg[i] > 9 ? 9 : cfg[i];
      req(2'h3, {12'h400, cfg[i]}, 8'hC0 + cfg[i]);
      chk({d, n[7:0]}, {8'hC0 + cfg[i], 8'(4 * e)});
      req(2'h2, {12'h400, cfg[i]}, 8'h00);
      chk({d, n[7:0]}, {8'hC0 + cfg[i], 8'(4 * e)});
    end
  endtask
  task t_rst;
    reset_pin = 1'h1;
    repeat (4) @(negedge mclk);
    reset_pin = 1'h0;
    repeat (2) @(negedge mclk);
    chk(core_reset, 1'h0);
    reset_pin = 1'h1;
    repeat (9) @(negedge mclk);
    chk(core_reset, 1'h1);
    reset_pin = 1'h0;
    wt(core_reset, 1'h0);
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    resetn = 1'h1;
    pullup_en = 1'h1;
    wt(core_reset, 1'h0);
    t_fetch;
    t_data;
    t_rst;
    t_fetch;
    summarize;
  end
endmodule
